// ==== hw/timer_register_transfer_ops.sv ====
// decoder and executor for the timer transfer instructions of a 4-bit core
// assumes the core presents one instruction word per cycle with a valid strobe,
// supplies A and B from its datapath, and writes back the nibbles returned here
//
// Contract
// - B:A loads timer 3 and its reload
// - B:A loads timer 4 and low reload
// - B:A loads only timer 4 high reload
// - low reload copies into timer 4 counter
// - B copies into accumulator, carry untouched
// - timer 1 splits into B and A
// - timer 2 or 3 splits into B, A
`timescale 1ns/1ps
module timer_register_transfer_ops
   import timer_xfer_pkg::*;
#(
   parameter int unsigned OW = timer_xfer_pkg::OPCODE_W  // instruction width
) (
   // clock and reset
   input  wire logic                               ref_clk_i,         // system clock
   input  wire logic                               rst_b_i,           // sync reset, low
   // instruction from the core
   input  wire logic                               instr_valid_i,     // word executes now
   input  wire logic [OW-1:0]                      opcode_i,          // instruction word
   // datapath operands
   input  wire logic [timer_xfer_pkg::NIBBLE_W-1:0] acc_i,            // accumulator
   input  wire logic [timer_xfer_pkg::NIBBLE_W-1:0] b_i,              // register B
   // counters owned by the timer logic outside
   input  wire logic [timer_xfer_pkg::BYTE_W-1:0]   first_timer_i,    // timer 1 count
   input  wire logic [timer_xfer_pkg::BYTE_W-1:0]   second_timer_i,   // timer 2 count
   // write-back to the core
   output logic                                    acc_wr_o,          // load acc_data_o
   output logic      [timer_xfer_pkg::NIBBLE_W-1:0] acc_data_o,        // new accumulator
   output logic                                    b_wr_o,            // load b_data_o
   output logic      [timer_xfer_pkg::NIBBLE_W-1:0] b_data_o,          // new register B
   output logic                                    executed_o,        // one of ours ran
   output logic                                    skip_o,            // never skips
   output logic                                    carry_wr_o,        // carry never written
   // timer 3 and 4 storage
   output logic      [timer_xfer_pkg::BYTE_W-1:0]   third_timer_o,     // timer 3 counter
   output logic      [timer_xfer_pkg::BYTE_W-1:0]   third_timer_reload_o,
   output logic      [timer_xfer_pkg::BYTE_W-1:0]   fourth_timer_o,    // timer 4 counter
   output logic      [timer_xfer_pkg::BYTE_W-1:0]   fourth_timer_reload_low_o,
   output logic      [timer_xfer_pkg::BYTE_W-1:0]   fourth_timer_reload_high_o
);

   // ---------------------------------------------------------------------
   // decode: one hit wire per opcode, gated by the valid strobe
   // ---------------------------------------------------------------------
   // a word that matches none of the codes, or any word seen while the valid
   // strobe is low, leaves storage alone and raises no pulse; the core is free
   // to run its other instructions over the same word meanwhile
   wire logic hit_load_third  = instr_valid_i && (opcode_i == OP_LOAD_THIRD_TIMER);
   wire logic hit_load_fourth = instr_valid_i && (opcode_i == OP_LOAD_FOURTH_TIMER);
   wire logic hit_load_high   = instr_valid_i && (opcode_i == OP_LOAD_FOURTH_HIGH);
   wire logic hit_copy_reload = instr_valid_i && (opcode_i == OP_COPY_LOW_RELOAD);
   wire logic hit_copy_b      = instr_valid_i && (opcode_i == OP_COPY_B_TO_ACC);
   wire logic hit_read_first  = instr_valid_i && (opcode_i == OP_READ_FIRST_TIMER);
   wire logic hit_read_second = instr_valid_i && (opcode_i == OP_READ_SECOND_TIMER);
   wire logic hit_read_third  = instr_valid_i && (opcode_i == OP_READ_THIRD_TIMER);

   // opcodes are distinct, so at most one hit is high; the priority is only form
   op_kind_t op_kind;                                    // recognised operation
   assign op_kind = hit_load_third  ? OPK_LOAD_THIRD  :
                    hit_load_fourth ? OPK_LOAD_FOURTH :
                    hit_load_high   ? OPK_LOAD_HIGH   :
                    hit_copy_reload ? OPK_COPY_RELOAD :
                    hit_copy_b      ? OPK_COPY_B      :
                    hit_read_first  ? OPK_READ_FIRST  :
                    hit_read_second ? OPK_READ_SECOND :
                    hit_read_third  ? OPK_READ_THIRD  : OPK_NONE;

   // ---------------------------------------------------------------------
   // timer 3 / 4 storage
   // ---------------------------------------------------------------------
   // timers 3 and 4 are kept here as plain bytes: counting and underflow live
   // elsewhere, so these only change when one of our writes lands
   // every byte has its own load strobe, which keeps each write local to the
   // registers that the instruction names and nothing else
   wire logic [BYTE_W-1:0] acc_b_byte = {b_i, acc_i};    // B high, A low
   logic      [BYTE_W-1:0] third_timer;                  // timer 3 counter
   logic      [BYTE_W-1:0] third_reload;                 // timer 3 reload
   logic      [BYTE_W-1:0] fourth_timer;                 // timer 4 counter
   logic      [BYTE_W-1:0] fourth_reload_low;            // timer 4 low reload
   logic      [BYTE_W-1:0] fourth_reload_high;           // timer 4 high reload

   // the third counter and reload use separate strobes even though they match,
   // so a later change to one write path does not silently move the other
   // load strobes; counter and reload share one edge so no split value shows
   wire logic load_third_ctr   = (op_kind == OPK_LOAD_THIRD);
   wire logic load_third_rld   = (op_kind == OPK_LOAD_THIRD);
   wire logic load_fourth_ctr  = (op_kind == OPK_LOAD_FOURTH) ||
                                 (op_kind == OPK_COPY_RELOAD);
   wire logic load_fourth_low  = (op_kind == OPK_LOAD_FOURTH);
   // the high reload alone is written; the timer 4 counter keeps its value untouched
   wire logic load_fourth_high = (op_kind == OPK_LOAD_HIGH);

   // the copy takes the low reload as it stood before this edge; only one word
   // executes per cycle, so a reload write and a copy never meet on one edge
   // timer 4 counter source: whole low reload byte on the copy, else B:A
   wire logic [BYTE_W-1:0] fourth_ctr_src =
      (op_kind == OPK_COPY_RELOAD) ? fourth_reload_low : acc_b_byte;

   // timer 3 counter
   byte_load_reg #(.WIDTH(BYTE_W)) u_third_timer (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .load_i      (load_third_ctr),
      .load_data_i (acc_b_byte),
      .value_o     (third_timer)
   );

   // timer 3 reload
   byte_load_reg #(.WIDTH(BYTE_W)) u_third_reload (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .load_i      (load_third_rld),
      .load_data_i (acc_b_byte),
      .value_o     (third_reload)
   );

   // timer 4 counter
   byte_load_reg #(.WIDTH(BYTE_W)) u_fourth_timer (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .load_i      (load_fourth_ctr),
      .load_data_i (fourth_ctr_src),
      .value_o     (fourth_timer)
   );

   // timer 4 low reload
   byte_load_reg #(.WIDTH(BYTE_W)) u_fourth_reload_low (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .load_i      (load_fourth_low),
      .load_data_i (acc_b_byte),
      .value_o     (fourth_reload_low)
   );

   // timer 4 high reload
   byte_load_reg #(.WIDTH(BYTE_W)) u_fourth_reload_high (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .load_i      (load_fourth_high),
      .load_data_i (acc_b_byte),
      .value_o     (fourth_reload_high)
   );

   // storage outputs follow the registers directly, so a write is visible
   // from the edge that takes it onward
   assign third_timer_o              = third_timer;
   assign third_timer_reload_o       = third_reload;
   assign fourth_timer_o             = fourth_timer;
   assign fourth_timer_reload_low_o  = fourth_reload_low;
   assign fourth_timer_reload_high_o = fourth_reload_high;

   // ---------------------------------------------------------------------
   // read path: pick the timer that the instruction names
   // ---------------------------------------------------------------------
   // timer 1 and 2 counts arrive from logic on this clock, so no synchroniser
   // sits on them; a count from another clock would need one upstream
   // the value is the one on the wires during the execute cycle; it is
   // captured at that edge, so a tick arriving later cannot tear the pair
   wire logic [BYTE_W-1:0] read_byte =
      (op_kind == OPK_READ_FIRST)  ? first_timer_i  :
      (op_kind == OPK_READ_SECOND) ? second_timer_i :
                                     third_timer;

   // one flag per write-back kind keeps the strobe logic readable
   wire logic is_read   = (op_kind == OPK_READ_FIRST) ||
                          (op_kind == OPK_READ_SECOND) ||
                          (op_kind == OPK_READ_THIRD);
   wire logic is_copy_b = (op_kind == OPK_COPY_B);

   // next values of the write-back nibbles
   wire logic [NIBBLE_W-1:0] acc_data_next =
      is_copy_b ? b_i : read_byte[LO_MSB:LO_LSB];
   wire logic [NIBBLE_W-1:0] b_data_next = read_byte[HI_MSB:HI_LSB];
   wire logic                acc_wr_next = is_read || is_copy_b;
   wire logic                b_wr_next   = is_read;
   wire logic                exec_next   = (op_kind != OPK_NONE);

   // registered copies of the next values above
   logic                acc_wr_reg;                      // accumulator strobe
   logic [NIBBLE_W-1:0] acc_data_reg;                    // accumulator value
   logic                b_wr_reg;                        // B strobe
   logic [NIBBLE_W-1:0] b_data_reg;                      // B value
   logic                exec_reg;                        // executed pulse

   // trade-off: registering the write-back costs a cycle of latency but keeps
   // the core's A and B inputs off any combinational loop through this block;
   // an instruction that reads A or B must not follow a read back to back
   // write-back stage: one cycle after the execute edge, for one cycle
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         acc_wr_reg   <= 1'b0;
         acc_data_reg <= NIBBLE_RESET;
         b_wr_reg     <= 1'b0;
         b_data_reg   <= NIBBLE_RESET;
         exec_reg     <= 1'b0;
      end else begin
         acc_wr_reg   <= acc_wr_next;
         acc_data_reg <= acc_data_next;
         b_wr_reg     <= b_wr_next;
         b_data_reg   <= b_data_next;
         exec_reg     <= exec_next;
      end
   end

   assign acc_wr_o   = acc_wr_reg;
   assign acc_data_o = acc_data_reg;
   assign b_wr_o     = b_wr_reg;
   assign b_data_o   = b_data_reg;
   assign executed_o = exec_reg;
   // none of these instructions skip or touch the carry flag; the ports stay
   // so the core's skip and carry logic can merge every decoder the same way
   assign skip_o     = 1'b0;
   assign carry_wr_o = 1'b0;

endmodule // timer_register_transfer_ops

// ==== hw/timer_xfer_pkg.sv ====
// constants shared by the timer register transfer decoder and its byte register
// assumes a 10-bit instruction word and a 4-bit accumulator / B register pair
package timer_xfer_pkg;

   // datapath widths
   localparam int unsigned OPCODE_W = 10;                  // instruction word width
   localparam int unsigned NIBBLE_W = 4;                   // accumulator and B width
   localparam int unsigned BYTE_W   = 8;                   // timer and reload width

   // nibble positions inside a timer byte
   localparam int unsigned HI_MSB = 7;                     // upper nibble top bit
   localparam int unsigned HI_LSB = 4;                     // upper nibble bottom bit
   localparam int unsigned LO_MSB = 3;                     // lower nibble top bit
   localparam int unsigned LO_LSB = 0;                     // lower nibble bottom bit

   // reset values
   localparam logic [7:0] BYTE_RESET   = 8'h00;            // timers and reloads
   localparam logic [3:0] NIBBLE_RESET = 4'h0;             // result nibbles

   // opcodes, bits 9 down to 0
   localparam logic [9:0] OP_LOAD_THIRD_TIMER  = 10'h232;  // B:A into timer 3 and reload
   localparam logic [9:0] OP_LOAD_FOURTH_TIMER = 10'h233;  // B:A into timer 4 and low reload
   localparam logic [9:0] OP_LOAD_FOURTH_HIGH  = 10'h237;  // B:A into high reload
   localparam logic [9:0] OP_COPY_LOW_RELOAD   = 10'h297;  // low reload into timer 4
   localparam logic [9:0] OP_COPY_B_TO_ACC     = 10'h01E;  // B into accumulator
   localparam logic [9:0] OP_READ_FIRST_TIMER  = 10'h270;  // timer 1 into B:A
   localparam logic [9:0] OP_READ_SECOND_TIMER = 10'h271;  // timer 2 into B:A
   localparam logic [9:0] OP_READ_THIRD_TIMER  = 10'h272;  // timer 3 into B:A

   // which operation the decoder has recognised
   typedef enum logic [3:0] {
      OPK_NONE,
      OPK_LOAD_THIRD,
      OPK_LOAD_FOURTH,
      OPK_LOAD_HIGH,
      OPK_COPY_RELOAD,
      OPK_COPY_B,
      OPK_READ_FIRST,
      OPK_READ_SECOND,
      OPK_READ_THIRD
   } op_kind_t;

endpackage

// ==== hw/byte_load_reg.sv ====
// one loadable 8-bit storage byte, used for the timer counters and reloads
// assumes the load strobe and data come from logic on the same clock
`timescale 1ns/1ps
module byte_load_reg #(
   parameter int unsigned WIDTH = 8                      // storage width
) (
   // clock and reset
   input  wire logic             ref_clk_i,             // system clock
   input  wire logic             rst_b_i,               // synchronous reset, low
   // load port
   input  wire logic             load_i,                // take load_data_i this edge
   input  wire logic [WIDTH-1:0] load_data_i,           // new contents
   // contents
   output logic      [WIDTH-1:0] value_o               // stored byte
);
   import timer_xfer_pkg::*;

   logic [WIDTH-1:0] value_reg;                          // held byte

   // hold unless loaded; reset clears to a known value
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         value_reg <= WIDTH'(BYTE_RESET);
      end else if (load_i) begin
         value_reg <= load_data_i;
      end
   end

   assign value_o = value_reg;

endmodule // byte_load_reg

// ==== test/timer_xfer_chk_assertions.sv ====
// concurrent checks on the timer transfer decoder ports
// assumes one clock and the package opcodes; bound into every decoder instance
`timescale 1ns/1ps
module timer_xfer_chk
   import timer_xfer_pkg::*;
(
   // clock, reset, instruction and operand inputs
   input wire logic       ref_clk_i,
   input wire logic       rst_b_i,
   input wire logic       instr_valid_i,
   input wire logic [9:0] opcode_i,
   input wire logic [3:0] acc_i,
   input wire logic [3:0] b_i,
   input wire logic [7:0] first_timer_i,
   input wire logic [7:0] second_timer_i,
   // results
   input wire logic       acc_wr_o,
   input wire logic [3:0] acc_data_o,
   input wire logic       b_wr_o,
   input wire logic [3:0] b_data_o,
   input wire logic       executed_o,
   input wire logic       skip_o,
   input wire logic       carry_wr_o,
   input wire logic [7:0] third_timer_o,
   input wire logic [7:0] third_timer_reload_o,
   input wire logic [7:0] fourth_timer_o,
   input wire logic [7:0] fourth_timer_reload_low_o,
   input wire logic [7:0] fourth_timer_reload_high_o
);
   import timer_xfer_pkg::*;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // shorthand signals, named so each property reads short
   wire take = instr_valid_i;
   wire [7:0] ba = {b_i, acc_i};
   wire [7:0] rd = {b_data_o, acc_data_o};
   wire rd_ok = acc_wr_o && b_wr_o && executed_o;
   property p_third;
      take && opcode_i == OP_LOAD_THIRD_TIMER |=> third_timer_o == $past(ba)
         && third_timer_reload_o == $past(ba) && !acc_wr_o && !b_wr_o;
   endproperty
   a_third: assert property (p_third) else $error("timer 3 load wrong");
   property p_fourth;
      take && opcode_i == OP_LOAD_FOURTH_TIMER |=> fourth_timer_o == $past(ba)
         && fourth_timer_reload_low_o == $past(ba);
   endproperty
   a_fourth: assert property (p_fourth) else $error("timer 4 load wrong");
   property p_high;
      take && opcode_i == OP_LOAD_FOURTH_HIGH |=>
         fourth_timer_reload_high_o == $past(ba) && $stable(fourth_timer_o);
   endproperty
   a_high: assert property (p_high) else $error("high reload load wrong");
   property p_copy;
      take && opcode_i == OP_COPY_LOW_RELOAD |=>
         fourth_timer_o == $past(fourth_timer_reload_low_o) && executed_o;
   endproperty
   a_copy: assert property (p_copy) else $error("reload copy wrong");
   property p_tab;
      take && opcode_i == OP_COPY_B_TO_ACC |=> acc_wr_o && !b_wr_o
         && acc_data_o == $past(b_i);
   endproperty
   a_tab: assert property (p_tab) else $error("b to acc wrong");
   property p_rd1;
      take && opcode_i == OP_READ_FIRST_TIMER |=> rd_ok && rd == $past(first_timer_i);
   endproperty
   a_rd1: assert property (p_rd1) else $error("timer 1 read wrong");
   property p_rd2;
      take && opcode_i == OP_READ_SECOND_TIMER |=> rd_ok && rd == $past(second_timer_i);
   endproperty
   a_rd2: assert property (p_rd2) else $error("timer 2 read wrong");
   property p_rd3;
      take && opcode_i == OP_READ_THIRD_TIMER |=> rd_ok && rd == $past(third_timer_o);
   endproperty
   a_rd3: assert property (p_rd3) else $error("timer 3 read wrong");
   property p_flags;
      !skip_o && !carry_wr_o;
   endproperty
   a_flags: assert property (p_flags) else $error("skip or carry touched");
   property p_idle;
      !take |=> !executed_o && !acc_wr_o && !b_wr_o;
   endproperty
   a_idle: assert property (p_idle) else $error("pulse without instruction");
   // main scenarios reached
   c_third: cover property (take && opcode_i == OP_LOAD_THIRD_TIMER);
   c_copy: cover property (take && opcode_i == OP_COPY_LOW_RELOAD);
   c_rd3: cover property (take && opcode_i == OP_READ_THIRD_TIMER);
endmodule // timer_xfer_chk
bind timer_register_transfer_ops timer_xfer_chk timer_xfer_chk_i (.ref_clk_i, .rst_b_i,
   .instr_valid_i, .opcode_i, .acc_i, .b_i, .first_timer_i, .second_timer_i, .acc_wr_o,
   .acc_data_o, .b_wr_o, .b_data_o, .executed_o, .skip_o, .carry_wr_o, .third_timer_o,
   .third_timer_reload_o, .fourth_timer_o, .fourth_timer_reload_low_o,
   .fourth_timer_reload_high_o);

// ==== test/core_regs_model.sv ====
// core datapath model: accumulator and B with write-back from the decoder
// assumes the bench presets A and B through set_i between instructions
`timescale 1ns/1ps
module core_regs_model (
   input  wire logic       ref_clk_i,
   input  wire logic       set_i,     // preset strobe from bench
   input  wire logic [3:0] set_acc_i,
   input  wire logic [3:0] set_b_i,
   input  wire logic       acc_wr_i,  // write-back strobes
   input  wire logic [3:0] acc_data_i,
   input  wire logic       b_wr_i,
   input  wire logic [3:0] b_data_i,
   output logic      [3:0] acc_o,
   output logic      [3:0] b_o
);
   // preset wins; a strobe loads only its own nibble
   always_ff @(posedge ref_clk_i) begin
      acc_o <= set_i ? set_acc_i : acc_wr_i ? acc_data_i : acc_o;
      b_o   <= set_i ? set_b_i : b_wr_i ? b_data_i : b_o;
   end
endmodule // core_regs_model

// ==== test/timer_register_transfer_ops_bench.sv ====
// bench for the timer transfer decoder with a core register model
// assumes results land in the model one edge after the execute edge
`timescale 1ns/1ps
module timer_register_transfer_ops_bench;
   import timer_xfer_pkg::*;
   logic ref_clk = 0, rst_b = 0, vld = 0, set = 0;
   logic [9:0] op = 10'h000;
   logic [3:0] sa = 4'h0, sb = 4'h0, acc, b, ad, bd;
   logic [7:0] t1 = 8'h00, t2 = 8'h00, t3, r3, t4, r4l, r4h;
   logic aw, bw, ex, sk, cw;
   int err_count = 0, n_compared = 0;
   always #2.5 ref_clk = ~ref_clk;
   core_regs_model core_regs_model_i (.ref_clk_i(ref_clk), .set_i(set), .set_acc_i(sa),
      .set_b_i(sb), .acc_wr_i(aw), .acc_data_i(ad), .b_wr_i(bw), .b_data_i(bd),
      .acc_o(acc), .b_o(b));
   timer_register_transfer_ops timer_register_transfer_ops_i (.ref_clk_i(ref_clk),
      .rst_b_i(rst_b), .instr_valid_i(vld), .opcode_i(op), .acc_i(acc), .b_i(b),
      .first_timer_i(t1), .second_timer_i(t2), .acc_wr_o(aw), .acc_data_o(ad),
      .b_wr_o(bw), .b_data_o(bd), .executed_o(ex), .skip_o(sk), .carry_wr_o(cw),
      .third_timer_o(t3), .third_timer_reload_o(r3), .fourth_timer_o(t4),
      .fourth_timer_reload_low_o(r4l), .fourth_timer_reload_high_o(r4h));
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // preset the core pair, then one instruction per call, back to back
   task automatic put(input logic [3:0] bv, input logic [3:0] av);
      @(posedge ref_clk) #1 set = 1; sb = bv; sa = av;
      @(posedge ref_clk) #1 set = 0;
   endtask
   task automatic run(input logic [9:0] o, input logic v);
      @(posedge ref_clk) #1 vld = v; op = o;
   endtask
   // end the stream; judge executed, acc and B strobes, skip and carry of the last edge
   task automatic idle(input logic [2:0] st);
      @(posedge ref_clk) #1 vld = 0;
      chk8({3'h0, ex, aw, bw, sk, cw}, {3'h0, st, 2'b00});
      @(posedge ref_clk) #1;
   endtask
   task automatic t_write();
      chk8(t4, 8'h00);
      put(4'hA, 4'h5); run(OP_LOAD_THIRD_TIMER, 1); idle(3'b100);
      chk8(t3, 8'hA5); chk8(r3, 8'hA5);
      put(4'h3, 4'hC); run(OP_LOAD_FOURTH_TIMER, 1); idle(3'b100);
      chk8(t4, 8'h3C); chk8(r4l, 8'h3C);
      put(4'hF, 4'h1); run(OP_LOAD_FOURTH_HIGH, 1); idle(3'b100);
      chk8(r4h, 8'hF1); chk8(t4, 8'h3C);
      run(OP_COPY_LOW_RELOAD, 1); idle(3'b100);
      chk8(t4, 8'h3C); chk8({b, acc}, 8'hF1);
   endtask
   task automatic t_tab();
      put(4'h9, 4'h2); run(OP_COPY_B_TO_ACC, 1); idle(3'b110);
      chk8({b, acc}, 8'h99);
   endtask
   task automatic t_read();
      t1 = 8'h6D; t2 = 8'hB4;
      run(OP_READ_FIRST_TIMER, 1); idle(3'b111);
      chk8({b, acc}, 8'h6D);
      run(OP_READ_SECOND_TIMER, 1); idle(3'b111);
      chk8({b, acc}, 8'hB4);
      put(4'h7, 4'hE); run(OP_LOAD_THIRD_TIMER, 1); run(OP_READ_THIRD_TIMER, 1);
      idle(3'b111);
      chk8({b, acc}, 8'h7E);
   endtask
   task automatic t_refuse();
      put(4'h0, 4'h0); run(OP_LOAD_THIRD_TIMER, 0); run(10'h3FF, 1);
      idle(3'b000);
      chk8(t3, 8'h7E); chk8({7'h00, ex}, 8'h00);
   endtask
   // mid-run reset beats a taken read, clears every storage byte and drops the pulses
   task automatic t_reset();
      @(posedge ref_clk) #1 rst_b = 0; vld = 1; op = OP_READ_THIRD_TIMER;
      @(posedge ref_clk) #1 rst_b = 1; vld = 0;
      chk8(t3, 8'h00); chk8(r3, 8'h00); chk8(r4h, 8'h00);
      chk8(t4, 8'h00); chk8(r4l, 8'h00);
      chk8({5'h00, ex, aw, bw}, 8'h00);
   endtask
   task automatic results();
      $display("compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #20000;
      err_count++;
      results();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      #1 rst_b = 1;
      t_write(); t_tab(); t_read(); t_refuse(); t_reset();
      results();
   end
endmodule // timer_register_transfer_ops_bench
